// ### hdl/fcd_params.svh
// constants for the fault capture and dma request block
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH
`define FCD_CNT_W       16
`define FCD_NCH         4
`define FCD_CNT_RST     16'h0000
`define FCD_CC_RST      16'h0000
`define FCD_PLAIN_CAPTURE_W      3
`define FCD_EV0_W       3
`define FCD_EV1_W       3
`endif

// ### hdl/fcd_pkg.sv
// types for the fault capture and dma request block
`include "fcd_params.svh"
`default_nettype none
package fcd_pkg;
   typedef enum logic [2:0] {
      FCD_PLAIN_CAPTURE_OFF   = 3'h0,
      FCD_PLAIN_CAPTURE_PLAIN = 3'h1,
      FCD_PLAIN_CAPTURE_MIN   = 3'h2,
      FCD_PLAIN_CAPTURE_MAX   = 3'h3,
      FCD_PLAIN_CAPTURE_LMIN  = 3'h4,
      FCD_PLAIN_CAPTURE_LMAX  = 3'h5,
      FCD_PLAIN_CAPTURE_EXTR  = 3'h6
   } fcd_plain_capture_t;
   typedef enum logic [2:0] {
      FCD_EV0_OFF  = 3'h0,
      FCD_EV0_RETR = 3'h1,
      FCD_EV0_DIR  = 3'h2,
      FCD_EV0_STOP = 3'h3,
      FCD_EV0_DEC  = 3'h4,
      FCD_EV0_PPW  = 3'h5,
      FCD_EV0_FLT  = 3'h6
   } fcd_ev0_t;
   typedef enum logic [2:0] {
      FCD_EV1_OFF   = 3'h0,
      FCD_EV1_RETR  = 3'h1,
      FCD_EV1_COUNT = 3'h2,
      FCD_EV1_START = 3'h3,
      FCD_EV1_INC   = 3'h4,
      FCD_EV1_FLT   = 3'h5
   } fcd_ev1_t;
   typedef struct packed {
      logic [`FCD_NCH-1:0] cc_wr;
      logic [`FCD_CNT_W-1:0] cc_wdata;
      logic [`FCD_NCH-1:0] cc_rd;
      logic [`FCD_NCH-1:0] mc_clr;
      logic err_clr;
      logic [`FCD_NCH-1:0] mc_ien_set;
      logic err_ien_set;
      logic dma_os_cmd;
   } fcd_sw_t;
endpackage
`default_nettype wire

// ### hdl/fcd_core.sv
// fault capture, extremum tracking, event actions and dma requests of a control timer
//
// Notes on behaviour
// - capture into a channel whose flag is still set raises overrun flag
// - writing one clears the overrun flag; zero leaves it
// - selected fault capture action stores counter into channel register on fault
// - plain capture behaves like ordinary channel capture
// - min capture keeps smallest value, notifies each new minimum
// - max capture keeps largest value, notifies each new maximum
// - local min/max notify modes signal on detected local extremum
// - extremum notify mode signals at every fault, without comparing values
// - notify modes store counter value at every fault
// - min needs nonzero start, max needs non-top start, else no captures
// - local modes capture always, flag on ge (min) or le (max)
// - event 0 performs one selected action on the counter or faults
// - event 1 performs one selected action on the counter or faults
// - without one-shot, update dma request asserts on each update condition
// - with one-shot, update trigger waits for software one-shot command
// - update dma request clears on dma acknowledge
// - channel dma request only on compare match, never in one-shot
// - reading channel register in capture clears its flag
// - writing one to error enable sets it; zero no effect
`include "fcd_params.svh"
`default_nettype none
module fcd_core
   import fcd_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 clk_en,
   input  wire fcd_sw_t              sw,
   input  wire fcd_plain_capture_t            fault_plain_capture_sel,
   input  wire logic                 dma_one_shot,
   input  wire fcd_ev0_t             ev0_sel,
   input  wire fcd_ev1_t             ev1_sel,
   input  wire logic [`FCD_CNT_W-1:0] top_val,
   input  wire logic [`FCD_NCH-1:0]  fault_in,
   input  wire logic [`FCD_NCH-1:0]  plain_capture_mode,
   input  wire logic [`FCD_NCH-1:0]  cmp_match,
   input  wire logic                 ev0_in,
   input  wire logic                 ev1_in,
   input  wire logic                 dma_ack_upd,
   input  wire logic [`FCD_NCH-1:0]  dma_ack_ch,
   output logic [`FCD_CNT_W-1:0]     count,
   output logic [`FCD_NCH*`FCD_CNT_W-1:0] compare_capture_reg,
   output logic [`FCD_NCH-1:0]       match_capture_flag,
   output logic                      err_flag,
   output logic [`FCD_NCH-1:0]       extremum_ev,
   output logic                      nrec_fault,
   output logic                      update_request,
   output logic [`FCD_NCH-1:0]       dma_req_ch,
   output logic                      irq,
   output logic                      running,
   output logic                      count_down
);
   ////////////////////////////////////////////////////////////////////////
   logic [`FCD_CNT_W-1:0] cnt_ff;
   logic                  run_ff;
   logic                  down_ff;
   logic                  upd_cond;
   logic                  retrig;
   logic                  ppw_plain_capture;
   logic [`FCD_NCH-1:0]   plain_capture_take;
   logic [`FCD_NCH-1:0]   flag_set;
   logic [`FCD_NCH-1:0]   ev_set;
   logic [`FCD_NCH-1:0]   ien_ff;
   logic                  err_ien_ff;
   logic                  os_pend_ff;
   logic [`FCD_CNT_W-1:0] cc_ff [`FCD_NCH];
   logic [`FCD_CNT_W-1:0] prev_ff [`FCD_NCH];

   assign retrig   = (ev0_in && ev0_sel == FCD_EV0_RETR) ||
                     (ev1_in && ev1_sel == FCD_EV1_RETR);
   assign ppw_plain_capture = ev0_in && ev0_sel == FCD_EV0_PPW;
   assign upd_cond = retrig || (run_ff && !down_ff && cnt_ff == top_val) ||
                     (run_ff && down_ff && cnt_ff == `FCD_CNT_RST);

   ////////////////////////////////////////////////////////////////////////
   // counter with event actions
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff  <= `FCD_CNT_RST;
         run_ff  <= 1'b0;
         down_ff <= 1'b0;
      end else if (clk_en) begin
         if (ev0_in && ev0_sel == FCD_EV0_STOP) begin
            run_ff <= 1'b0;
         end else if (ev1_in && ev1_sel == FCD_EV1_START) begin
            run_ff <= 1'b1;
         end
         if (ev0_sel == FCD_EV0_DIR) begin
            down_ff <= ev0_in;
         end
         if (retrig) begin
            cnt_ff <= down_ff ? top_val : `FCD_CNT_RST;
            run_ff <= 1'b1;
         end else if (ev0_in && ev0_sel == FCD_EV0_DEC) begin
            cnt_ff <= cnt_ff - 16'h0001;
         end else if (ev1_in && ev1_sel == FCD_EV1_INC) begin
            cnt_ff <= cnt_ff + 16'h0001;
         end else if (ev1_in && ev1_sel == FCD_EV1_COUNT) begin
            cnt_ff <= down_ff ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
         end else if (run_ff) begin
            if (!down_ff) begin
               cnt_ff <= (cnt_ff == top_val) ? `FCD_CNT_RST : cnt_ff + 16'h0001;
            end else begin
               cnt_ff <= (cnt_ff == `FCD_CNT_RST) ? top_val : cnt_ff - 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nrec_fault <= 1'b0;
      end else if (clk_en) begin
         nrec_fault <= (ev0_in && ev0_sel == FCD_EV0_FLT) ||
                       (ev1_in && ev1_sel == FCD_EV1_FLT);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per channel capture
   generate
      for (genvar i = 0; i < `FCD_NCH; i++) begin : g_ch
         logic flt;
         logic ok_min;
         logic ok_max;
         assign flt = fault_in[i] || (ppw_plain_capture && plain_capture_mode[i]);
         assign ok_min = cc_ff[i] != `FCD_CC_RST;
         assign ok_max = cc_ff[i] != top_val;
         always_comb begin
            plain_capture_take[i] = 1'b0;
            flag_set[i]  = 1'b0;
            ev_set[i]    = 1'b0;
            if (flt) begin
               unique case (fault_plain_capture_sel)
                  FCD_PLAIN_CAPTURE_PLAIN: begin
                     plain_capture_take[i] = 1'b1;
                     flag_set[i]  = 1'b1;
                  end
                  FCD_PLAIN_CAPTURE_MIN: begin
                     plain_capture_take[i] = ok_min && cnt_ff < cc_ff[i];
                     flag_set[i]  = plain_capture_take[i];
                     ev_set[i]    = plain_capture_take[i];
                  end
                  FCD_PLAIN_CAPTURE_MAX: begin
                     plain_capture_take[i] = ok_max && cnt_ff > cc_ff[i];
                     flag_set[i]  = plain_capture_take[i];
                     ev_set[i]    = plain_capture_take[i];
                  end
                  FCD_PLAIN_CAPTURE_LMIN: begin
                     plain_capture_take[i] = 1'b1;
                     flag_set[i]  = cnt_ff >= prev_ff[i];
                     ev_set[i]    = flag_set[i];
                  end
                  FCD_PLAIN_CAPTURE_LMAX: begin
                     plain_capture_take[i] = 1'b1;
                     flag_set[i]  = cnt_ff <= prev_ff[i];
                     ev_set[i]    = flag_set[i];
                  end
                  FCD_PLAIN_CAPTURE_EXTR: begin
                     plain_capture_take[i] = 1'b1;
                     flag_set[i]  = 1'b1;
                     ev_set[i]    = 1'b1;
                  end
                  default: begin
                     plain_capture_take[i] = 1'b0;
                  end
               endcase
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               cc_ff[i]   <= `FCD_CC_RST;
               prev_ff[i] <= `FCD_CC_RST;
            end else if (clk_en) begin
               if (plain_capture_take[i]) begin
                  cc_ff[i]   <= cnt_ff;
                  prev_ff[i] <= cnt_ff;
               end else if (sw.cc_wr[i]) begin
                  cc_ff[i] <= sw.cc_wdata;
               end
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               match_capture_flag[i] <= 1'b0;
            end else if (clk_en) begin
               if (flag_set[i] || (cmp_match[i] && !plain_capture_mode[i])) begin
                  match_capture_flag[i] <= 1'b1;
               end else if (sw.mc_clr[i] || (sw.cc_rd[i] && plain_capture_mode[i])) begin
                  match_capture_flag[i] <= 1'b0;
               end
            end
         end
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               dma_req_ch[i] <= 1'b0;
            end else if (clk_en) begin
               if (cmp_match[i] && !dma_one_shot) begin
                  dma_req_ch[i] <= 1'b1;
               end else if (dma_ack_ch[i] || dma_one_shot) begin
                  dma_req_ch[i] <= 1'b0;
               end
            end
         end
         assign compare_capture_reg[i*`FCD_CNT_W +: `FCD_CNT_W] = cc_ff[i];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // overrun flag, enables, notify events, interrupt
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_flag <= 1'b0;
      end else if (clk_en) begin
         if (|(plain_capture_take & match_capture_flag)) begin
            err_flag <= 1'b1;
         end else if (sw.err_clr) begin
            err_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ien_ff     <= '0;
         err_ien_ff <= 1'b0;
      end else if (clk_en) begin
         ien_ff <= ien_ff | sw.mc_ien_set;
         if (sw.err_ien_set) begin
            err_ien_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         extremum_ev <= '0;
         irq         <= 1'b0;
      end else if (clk_en) begin
         extremum_ev <= ev_set;
         irq <= (err_flag && err_ien_ff) || |(match_capture_flag & ien_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // update dma request
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         os_pend_ff     <= 1'b0;
         update_request <= 1'b0;
      end else if (clk_en) begin
         if (upd_cond && dma_one_shot) begin
            os_pend_ff <= 1'b1;
         end else if (sw.dma_os_cmd && os_pend_ff) begin
            os_pend_ff <= 1'b0;
         end
         if ((upd_cond && !dma_one_shot) ||
             (dma_one_shot && sw.dma_os_cmd && os_pend_ff)) begin
            update_request <= 1'b1;
         end else if (dma_ack_upd) begin
            update_request <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count      <= `FCD_CNT_RST;
         running    <= 1'b0;
         count_down <= 1'b0;
      end else if (clk_en) begin
         count      <= cnt_ff;
         running    <= run_ff;
         count_down <= down_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_overrun_set: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && |(plain_capture_take & match_capture_flag) |=> err_flag)
      else $error("overrun not flagged");
   a_err_hold: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && err_flag && !sw.err_clr |=> err_flag)
      else $error("overrun flag lost");
   a_plain_plain_capture: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && fault_in[0] && fault_plain_capture_sel == FCD_PLAIN_CAPTURE_PLAIN
      |=> compare_capture_reg[`FCD_CNT_W-1:0] == $past(cnt_ff))
      else $error("plain capture wrong");
   a_min_keep: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && fault_plain_capture_sel == FCD_PLAIN_CAPTURE_MIN && !sw.cc_wr[0]
      |=> cc_ff[0] <= $past(cc_ff[0]))
      else $error("min capture grew");
   a_max_keep: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && fault_plain_capture_sel == FCD_PLAIN_CAPTURE_MAX && !sw.cc_wr[0]
      |=> cc_ff[0] >= $past(cc_ff[0]))
      else $error("max capture shrank");
   a_upd_dma: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && upd_cond && !dma_one_shot |=> update_request)
      else $error("update dma missing");
   a_upd_ack: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && dma_ack_upd && !upd_cond && !sw.dma_os_cmd |=> !update_request)
      else $error("update dma not cleared");
   a_ch_dma_os: assert property (@(posedge clk) disable iff (!arst_n)
      clk_en && dma_one_shot ##1 clk_en && dma_one_shot |=> dma_req_ch == '0)
      else $error("channel dma in one-shot");
endmodule
`default_nettype wire

// ### tb/fcd_dma_model.sv
// dma controller stand-in: acknowledges a held request after a set latency
`default_nettype none
module fcd_dma_model (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [2:0] lat,
   input  wire logic       req,
   output logic            ack,
   output logic [7:0]      n_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wait_ff <= 4'h0;
         ack <= 1'b0;
         n_ack <= 8'h00;
      end else if (ack) begin
         // request drops on the ack edge, so skip one cycle before looking again
         ack <= 1'b0;
         wait_ff <= 4'h0;
      end else if (req === 1'b1) begin
         if (wait_ff == {1'b0, lat}) begin
            ack <= 1'b1;
            n_ack <= n_ack + 8'h01;
         end else begin
            wait_ff <= wait_ff + 4'h1;
         end
      end else begin
         wait_ff <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// ### tb/fault_capture_dma_requests_bench.sv
// self-checking bench of the fault capture and dma request block
`include "fcd_params.svh"
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fault_capture_dma_requests_bench
   import fcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   fcd_sw_t     sw = '0;
   fcd_plain_capture_t   plain_capture_sel = FCD_PLAIN_CAPTURE_PLAIN;
   fcd_ev0_t    ev0_sel = FCD_EV0_DEC;
   fcd_ev1_t    ev1_sel = FCD_EV1_INC;
   logic        os = 1'b0, ev0 = 1'b0, ev1 = 1'b0, watch = 1'b0;
   logic [3:0]  fault = 4'h0, match = 4'h0, cmode = 4'hf, ack_ch, flag, xev, dreq;
   logic        ack_upd, err, nrec, upd, irq, running, cdown;
   logic [15:0] count, wd = 16'h0, m_cc = 16'h0, m_cnt = 16'h0;
   logic [63:0] ccr;
   logic [39:0] n_ack;
   logic [14:0] lat = 15'h0;
   logic        m_flag = 1'b0, m_err = 1'b0, m_irq = 1'b0;
   logic [34:0] obs, exp_v, prev = '0, note_q[$];
   int          n_mismatch = 0, n_tests = 0, seed = 87, n_xev = 0, n_nrec = 0;

   fcd_core u_fcd_core (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .sw(sw),
      .fault_plain_capture_sel(plain_capture_sel), .dma_one_shot(os), .ev0_sel(ev0_sel), .ev1_sel(ev1_sel),
      .top_val(16'hffff), .fault_in(fault), .plain_capture_mode(cmode), .cmp_match(match),
      .ev0_in(ev0), .ev1_in(ev1), .dma_ack_upd(ack_upd), .dma_ack_ch(ack_ch),
      .count(count), .compare_capture_reg(ccr), .match_capture_flag(flag),
      .err_flag(err), .extremum_ev(xev), .nrec_fault(nrec), .update_request(upd),
      .dma_req_ch(dreq), .irq(irq), .running(running), .count_down(cdown));
   fcd_dma_model u_dma[4:0] (.clk(clk), .arst_n(arst_n), .lat(lat), .req({dreq, upd}),
      .ack({ack_ch, ack_upd}), .n_ack(n_ack));

   initial forever #4 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // watcher: while watch is set, every change of the observed outputs consumes the oldest note
   assign obs = {flag[0], err, irq, ccr[15:0], count};
   always @(posedge clk) begin
      if (xev[0] === 1'b1) n_xev++;
      if (nrec === 1'b1) n_nrec++;
      if (watch && obs !== prev) begin
         // pop once: the macro reads its expected value twice on a mismatch
         exp_v = prev;
         if (note_q.size() > 0) exp_v = note_q.pop_front();
         `CHK(obs, exp_v)
      end
      prev = obs;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic note();
      note_q.push_back({m_flag, m_err, m_irq, m_cc, m_cnt});
   endtask
   task automatic act(input int k);
      @(posedge clk);
      case (k)
         0: fault[0] <= 1'b1;
         1: ev0 <= 1'b1;
         2: ev1 <= 1'b1;
         3: sw.err_clr <= 1'b1;
         4: sw.cc_rd <= 4'h3;
         5: sw.mc_clr[0] <= 1'b1;
         6: sw.err_ien_set <= 1'b1;
         7: sw.dma_os_cmd <= 1'b1;
         8: match[1] <= 1'b1;
         10: sw.mc_ien_set <= 4'h2;
         default: begin
            sw.cc_wr[0] <= 1'b1;
            sw.cc_wdata <= wd;
         end
      endcase
      @(posedge clk);
      {fault, ev0, ev1, match} <= '0;
      sw <= '0;
      repeat (3) @(posedge clk);
   endtask
   task automatic wait_ack(input int i, input logic [7:0] e);
      int k;
      k = 0;
      while (n_ack[8*i +: 8] !== e && k < 200) begin
         @(posedge clk);
         k++;
      end
      `CHK(n_ack[8*i +: 8], e)
   endtask
   task automatic print_verdict();
      $display("counts tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      lat <= 15'($random(seed));
      watch = 1'b1;
      for (int i = 1; i <= 6; i++) begin
         ev1_sel <= (i > 3) ? FCD_EV1_COUNT : FCD_EV1_INC;
         m_cnt = 16'(i); note();
         act(2);
      end
      m_cnt = 16'h5; note(); act(1);
      act(6);
      m_flag = 1'b1; m_cc = 16'h5; note(); act(0);
      m_err = 1'b1; note(); m_irq = 1'b1; note(); act(0);
      m_err = 1'b0; note(); m_irq = 1'b0; note(); act(3);
      m_flag = 1'b0; note(); act(4);
      $display("test plain capture done");
      plain_capture_sel <= FCD_PLAIN_CAPTURE_MIN;
      wd = 16'h0; m_cc = 16'h0; note(); act(9);
      act(0);
      wd = 16'h9; m_cc = 16'h9; note(); act(9);
      m_flag = 1'b1; m_cc = 16'h5; note(); act(0);
      m_flag = 1'b0; note(); act(5);
      act(0);
      m_cnt = 16'h4; note(); act(1);
      m_flag = 1'b1; m_cc = 16'h4; note(); act(0);
      m_flag = 1'b0; note(); act(5);
      plain_capture_sel <= FCD_PLAIN_CAPTURE_MAX;
      wd = 16'hffff; m_cc = 16'hffff; note(); act(9);
      act(0);
      wd = 16'h2; m_cc = 16'h2; note(); act(9);
      m_flag = 1'b1; m_cc = 16'h4; note(); act(0);
      m_flag = 1'b0; note(); act(5);
      `CHK(n_xev, 3)
      $display("test extremum capture done");
      plain_capture_sel <= FCD_PLAIN_CAPTURE_LMIN;
      m_flag = 1'b1; note(); act(0);
      m_flag = 1'b0; note(); act(5);
      m_cnt = 16'h3; note(); act(1);
      m_cc = 16'h3; note(); act(0);
      plain_capture_sel <= FCD_PLAIN_CAPTURE_LMAX;
      m_flag = 1'b1; note(); act(0);
      m_flag = 1'b0; note(); act(5);
      watch = 1'b0;
      `CHK(note_q.size(), 0)
      act(2);
      plain_capture_sel <= FCD_PLAIN_CAPTURE_EXTR;
      act(0);
      `CHK(ccr[15:0], 16'h4)
      `CHK(n_xev, 6)
      $display("test local capture done");
      ev0_sel <= FCD_EV0_PPW;
      act(1);
      `CHK(ccr[31:16], 16'h4)
      ev0_sel <= FCD_EV0_FLT;
      act(1);
      ev1_sel <= FCD_EV1_FLT;
      act(2);
      `CHK(n_nrec, 2)
      ev0_sel <= FCD_EV0_RETR;
      act(1);
      wait_ack(0, 8'h1);
      os <= 1'b1;
      act(1);
      repeat (6) @(posedge clk);
      `CHK(upd, 1'b0)
      act(7);
      wait_ack(0, 8'h2);
      act(8);
      `CHK(dreq[1], 1'b0)
      os <= 1'b0;
      cmode <= 4'hd;
      act(8);
      wait_ack(2, 8'h1);
      act(4);
      `CHK(flag[1:0], 2'h2)
      act(3);
      `CHK(irq, 1'b0)
      act(10);
      `CHK(irq, 1'b1)
      $display("test dma requests done");
      ev0_sel <= FCD_EV0_STOP;
      act(1);
      `CHK(running, 1'b0)
      ev1_sel <= FCD_EV1_START;
      act(2);
      `CHK(running, 1'b1)
      ev0_sel <= FCD_EV0_DIR;
      ev0 <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(cdown, 1'b1)
      ev0 <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(cdown, 1'b0)
      $display("test counter events done");
      print_verdict();
   end
endmodule
`default_nettype wire
